// ---- include/rail_seq_map.vh ----
// register offsets, field positions, reset values and timing for the rail sequencer
// assumes a 100 MHz system clock and a 32-bit apb slave with word-aligned registers
`ifndef RAIL_SEQ_MAP_VH
`define RAIL_SEQ_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// byte addresses
`define ADDR_ENABLE 8'h00
`define ADDR_ORDER1 8'h04
`define ADDR_ORDER2 8'h08
`define ADDR_ORDER3 8'h0c
`define ADDR_ORDER4 8'h10
`define ADDR_ORDER5 8'h14
`define ADDR_ORDER6 8'h18
`define ADDR_GOODCFG 8'h1c
`define ADDR_STATUS 8'h20

////////////////////////////////////////////////////////////////////////////////
// order6 control bits, above the gap 5 and gap 6 fields
`define BIT_UP 8
`define BIT_DOWN 9
`define BIT_INSTANT 10
`define BIT_OFF 11
// good config: delay field, regulator masks, switch-as-regulator bits
`define POS_GDLY 0
`define POS_MASK 2
`define POS_REGCFG 4

////////////////////////////////////////////////////////////////////////////////
// reset values; rail order: buck 1..3, switch c, switch d, always-on a, b
`define RST_ORDER 28'hef54321
`define RST_GAPS 24'h111111
`define RST_GDLY 2'h0
`define RST_MASK 2'h3
`define RST_REGCFG 2'h3
`define RST_OFF 1'h1

////////////////////////////////////////////////////////////////////////////////
// timing: clock and tick periods in nanoseconds, delays in milliseconds
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000000
`define MONITOR_MS 5
`define HOLD_TIMEOUT_MS 5000
`define LONG_PRESS_MS 8000
`define GDLY0_MS 20
`define GDLY1_MS 100
`define GDLY2_MS 200
`define GDLY3_MS 400
`define GAP_MAX_MS 10

////////////////////////////////////////////////////////////////////////////////
// sequencer states
`define ST_OFF 3'h0
`define ST_WAIT 3'h1
`define ST_UP 3'h2
`define ST_ACTIVE 3'h3
`define ST_DOWN 3'h4
`define ST_SLEEP 3'h5

`endif

// ---- src/rail_sequencer_power_good.v ----
// rail power-up/power-down sequencer with power-good supervision and apb registers
// assumes all inputs synchronous to clock_in; rail good inputs are already deglitched
`timescale 1ns/1ps
`include "rail_seq_map.vh"

// How it works
// - strobes order rails, gaps 1 to 10 ms
// - sequence config returns to defaults on sleep/off/reset
// - power-up fires strobe 1, then gaps, up to 7
// - one strobe per rail, gaps in last registers
// - off wakes on button, usb, adaptor, hard reset edges
// - hold must be high within 5 s else down
// - in sleep, hold alone starts power-up
// - up bit starts sequencer, self-clears when done
// - strobe zero rails are never sequenced
// - enable register locked while sequencing, reflects rails
// - power-down runs strobe 7 down to 1
// - instant-down drops sequenced rails together
// - five triggers start power-down
// - off clears unsequenced rails, sleep keeps them
// - strobe 15 at wake, 14 after gap 6
// - always-on strobes go down with off bit, hard reset, long press, hold timeout or fault
// - enabled rail good lost means fault, off
// - monitoring starts 5 ms after rail enable
// - good outputs wait good-delay after sequencing
// - goods low on reset or all rails off
// - aux good follows always-on regulators
// - main good covers bucks, regulators, unmasked always-on
// - main good low outside completed active state
module rail_sequencer_power_good #(
  parameter TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
  parameter HOLD_TIMEOUT_MS = `HOLD_TIMEOUT_MS,
  parameter LONG_PRESS_MS = `LONG_PRESS_MS
) (
  input wire clock_in,
  input wire sys_rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire power_hold_input_in,
  input wire button_input_n_in,
  input wire hard_reset_input_n_in,
  input wire usb_in,
  input wire adaptor_in,
  input wire undervoltage_lockout_in,
  input wire overtemp_shutdown_in,
  input wire [6:0] rail_good_in,
  output reg [6:0] rail_enable_out,
  output reg main_good_output_out,
  output reg aux_good_output_out
);

  // rails whose strobe field equals the given strobe number
  function [6:0] strobe_mask;
    input [27:0] ord;
    input [3:0] s;
    integer i;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        strobe_mask[i] = (ord[4*i +: 4] == s);
      end
    end
  endfunction

  // gap field to milliseconds: field + 1, capped at the maximum
  function [12:0] gap_ms;
    input [3:0] f;
    begin
      if (f >= 4'h9) begin
        gap_ms = 13'd`GAP_MAX_MS;
      end else begin
        gap_ms = {9'h000, f} + 13'h0001;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick
  reg [16:0] tick_cnt_q;
  reg tick_q;

  // one divider feeds every ms count, so all delays share a phase
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      tick_cnt_q <= 17'h00000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES[16:0] - 17'h00001) begin
      tick_cnt_q <= 17'h00000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 17'h00001;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and configuration
  reg [2:0] state_q;
  reg [3:0] strobe_q;
  reg [12:0] gap_q;
  reg dest_off_q;
  reg [27:0] order_q;
  reg [23:0] gaps_q;
  reg up_bit_q;
  reg down_bit_q;
  reg instant_q;
  reg off_bit_q;
  reg [1:0] gdly_q;
  reg [1:0] mask_q;
  reg [1:0] regcfg_q;
  reg [12:0] wait_ms_q;
  reg [12:0] press_ms_q;
  reg aon_run_q;
  reg [12:0] aon_ms_q;
  reg [8:0] good_ms_q;
  reg good_run_q;
  reg good_done_q;
  reg hold_prev_q;
  reg btn_prev_q;
  reg usb_prev_q;
  reg ac_prev_q;
  reg rst_prev_q;
  reg [2:0] mon_q [0:6];

  wire access = psel_in & penable_in & pready_out;
  wire wr = access & pwrite_in;
  wire busy = (state_q == `ST_UP) | (state_q == `ST_DOWN);
  wire wake_edge = (btn_prev_q & ~button_input_n_in) | (usb_in & ~usb_prev_q) |
                   (adaptor_in & ~ac_prev_q) | (hard_reset_input_n_in & ~rst_prev_q);
  wire healthy = ~undervoltage_lockout_in & ~overtemp_shutdown_in;
  wire [6:0] seq_rails = ~strobe_mask(order_q, 4'h0) & ~strobe_mask(order_q, 4'he) &
                         ~strobe_mask(order_q, 4'hf);
  wire [6:0] aon_rails = strobe_mask(order_q, 4'he) | strobe_mask(order_q, 4'hf);

  // monitored rails: enabled and past the settle window; switches only when regcfg_q marks them as regulators
  reg [6:0] mon_ready;
  integer k;
  always @* begin
    for (k = 0; k < 7; k = k + 1) begin
      mon_ready[k] = rail_enable_out[k] & (mon_q[k] == 3'd`MONITOR_MS);
    end
    mon_ready[3] = mon_ready[3] & regcfg_q[0];
    mon_ready[4] = mon_ready[4] & regcfg_q[1];
  end
  wire [6:0] bad = mon_ready & ~rail_good_in;
  wire fault = |bad;
  // main good covers bucks, switches as regulators, always-on when unmasked
  wire main_bad = |(bad & {~mask_q, 5'h1f});

  // settle counters restart whenever a rail is disabled
  integer m;
  always @(posedge clock_in) begin
    for (m = 0; m < 7; m = m + 1) begin
      if (sys_rst_in | ~rail_enable_out[m]) begin
        mon_q[m] <= 3'h0;
      end else if (tick_q & (mon_q[m] != 3'd`MONITOR_MS)) begin
        mon_q[m] <= mon_q[m] + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_q <= `ST_OFF;
      strobe_q <= 4'h0;
      gap_q <= 13'h0000;
      dest_off_q <= 1'b1;
      order_q <= `RST_ORDER;
      gaps_q <= `RST_GAPS;
      up_bit_q <= 1'b0;
      down_bit_q <= 1'b0;
      instant_q <= 1'b0;
      off_bit_q <= `RST_OFF;
      gdly_q <= `RST_GDLY;
      mask_q <= `RST_MASK;
      regcfg_q <= `RST_REGCFG;
      wait_ms_q <= 13'h0000;
      press_ms_q <= 13'h0000;
      aon_run_q <= 1'b0;
      aon_ms_q <= 13'h0000;
      rail_enable_out <= 7'h00;
      hold_prev_q <= 1'b0;
      btn_prev_q <= 1'b1;
      usb_prev_q <= 1'b0;
      ac_prev_q <= 1'b0;
      rst_prev_q <= 1'b1;
    end else begin
      hold_prev_q <= power_hold_input_in;
      btn_prev_q <= button_input_n_in;
      usb_prev_q <= usb_in;
      ac_prev_q <= adaptor_in;
      rst_prev_q <= hard_reset_input_n_in;
      // register writes; enable is refused while the sequencer runs
      if (wr) begin
        case (paddr_in)
          `ADDR_ENABLE: begin
            if (!busy) begin
              rail_enable_out <= pwdata_in[6:0];
            end
          end
          `ADDR_ORDER1: order_q[7:0] <= pwdata_in[7:0];
          `ADDR_ORDER2: order_q[15:8] <= pwdata_in[7:0];
          `ADDR_ORDER3: order_q[23:16] <= pwdata_in[7:0];
          `ADDR_ORDER4: order_q[27:24] <= pwdata_in[3:0];
          `ADDR_ORDER5: gaps_q[15:0] <= pwdata_in[15:0];
          `ADDR_ORDER6: begin
            gaps_q[23:16] <= pwdata_in[7:0];
            up_bit_q <= pwdata_in[`BIT_UP] | up_bit_q;
            down_bit_q <= pwdata_in[`BIT_DOWN] | down_bit_q;
            instant_q <= pwdata_in[`BIT_INSTANT];
            off_bit_q <= pwdata_in[`BIT_OFF];
          end
          `ADDR_GOODCFG: begin
            gdly_q <= pwdata_in[`POS_GDLY +: 2];
            mask_q <= pwdata_in[`POS_MASK +: 2];
            regcfg_q <= pwdata_in[`POS_REGCFG +: 2];
          end
          default: begin
          end
        endcase
      end
      // always-on strobe 14 follows strobe 15 by gap 6, beside the main sequencer
      if (aon_run_q & tick_q) begin
        if (aon_ms_q <= 13'h0001) begin
          aon_run_q <= 1'b0;
          rail_enable_out <= rail_enable_out | strobe_mask(order_q, 4'he);
        end else begin
          aon_ms_q <= aon_ms_q - 13'h0001;
        end
      end
      if (gap_q != 13'h0000 && tick_q) begin
        gap_q <= gap_q - 13'h0001;
      end
      // long press counts only while the button stays low
      if (button_input_n_in) begin
        press_ms_q <= 13'h0000;
      end else if (tick_q && press_ms_q != LONG_PRESS_MS[12:0]) begin
        press_ms_q <= press_ms_q + 13'h0001;
      end
      case (state_q)
        `ST_OFF, `ST_SLEEP: begin
          // sleep accepts the hold level alone as a wake request
          if (hard_reset_input_n_in && healthy && (wake_edge ||
              (state_q == `ST_SLEEP && power_hold_input_in))) begin
            rail_enable_out <= rail_enable_out | strobe_mask(order_q, 4'hf);
            aon_run_q <= 1'b1;
            aon_ms_q <= gap_ms(gaps_q[23:20]);
            wait_ms_q <= 13'h0000;
            state_q <= `ST_WAIT;
          end
        end
        `ST_WAIT: begin
          // level check, so hold may already be high before the wake event
          if (power_hold_input_in) begin
            state_q <= `ST_UP;
            strobe_q <= 4'h1;
            gap_q <= 13'h0000;
          end else if (wait_ms_q == HOLD_TIMEOUT_MS[12:0]) begin
            state_q <= `ST_DOWN;
            strobe_q <= 4'h7;
            dest_off_q <= 1'b1;
          end else if (tick_q) begin
            wait_ms_q <= wait_ms_q + 13'h0001;
          end
        end
        `ST_UP: begin
          if (gap_q == 13'h0000) begin
            rail_enable_out <= rail_enable_out | strobe_mask(order_q, strobe_q);
            if (strobe_q == 4'h7) begin
              state_q <= `ST_ACTIVE;
              // a software set in the completing cycle wins over the self-clear
              up_bit_q <= wr & (paddr_in == `ADDR_ORDER6) & pwdata_in[`BIT_UP];
            end else begin
              gap_q <= gap_ms(gaps_q[4*(strobe_q-4'h1) +: 4]);
              strobe_q <= strobe_q + 4'h1;
            end
          end
        end
        `ST_ACTIVE: begin
          if (up_bit_q) begin
            state_q <= `ST_UP;
            strobe_q <= 4'h1;
            gap_q <= 13'h0000;
          end else if (down_bit_q || (hold_prev_q && !power_hold_input_in) ||
                       press_ms_q == LONG_PRESS_MS[12:0] || !hard_reset_input_n_in) begin
            state_q <= `ST_DOWN;
            strobe_q <= 4'h7;
            gap_q <= 13'h0000;
            down_bit_q <= wr & (paddr_in == `ADDR_ORDER6) & pwdata_in[`BIT_DOWN];
            dest_off_q <= off_bit_q | ~hard_reset_input_n_in |
                          (press_ms_q == LONG_PRESS_MS[12:0]);
          end
        end
        `ST_DOWN: begin
          if (gap_q == 13'h0000) begin
            if (instant_q) begin
              rail_enable_out <= rail_enable_out & ~seq_rails;
            end else begin
              rail_enable_out <= rail_enable_out & ~strobe_mask(order_q, strobe_q);
            end
            if (instant_q || strobe_q == 4'h1) begin
              // last strobe: off drops everything left, sleep keeps unsequenced rails
              if (dest_off_q) begin
                rail_enable_out <= 7'h00;
                aon_run_q <= 1'b0;
                state_q <= `ST_OFF;
              end else begin
                state_q <= `ST_SLEEP;
              end
              order_q <= `RST_ORDER;
              gaps_q <= `RST_GAPS;
              instant_q <= 1'b0;
              off_bit_q <= `RST_OFF;
              gdly_q <= `RST_GDLY;
              mask_q <= `RST_MASK;
              regcfg_q <= `RST_REGCFG;
              up_bit_q <= 1'b0;
              down_bit_q <= 1'b0;
            end else begin
              gap_q <= gap_ms(gaps_q[4*(strobe_q-4'h2) +: 4]);
              strobe_q <= strobe_q - 4'h1;
            end
          end
        end
        default: state_q <= `ST_OFF;
      endcase
      // a fault overrides everything: all rails off at once, defaults, off state
      if (state_q != `ST_OFF && (fault || !healthy)) begin
        rail_enable_out <= 7'h00;
        aon_run_q <= 1'b0;
        state_q <= `ST_OFF;
        order_q <= `RST_ORDER;
        gaps_q <= `RST_GAPS;
        instant_q <= 1'b0;
        off_bit_q <= `RST_OFF;
        gdly_q <= `RST_GDLY;
        mask_q <= `RST_MASK;
        regcfg_q <= `RST_REGCFG;
        up_bit_q <= 1'b0;
        down_bit_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-good outputs
  reg aux_ok_q;

  // good delay starts when the sequencer completes into active
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      good_ms_q <= 9'h000;
      good_run_q <= 1'b0;
      good_done_q <= 1'b0;
      aux_ok_q <= 1'b0;
      main_good_output_out <= 1'b0;
      aux_good_output_out <= 1'b0;
    end else begin
      if (state_q == `ST_UP && gap_q == 13'h0000 && strobe_q == 4'h7) begin
        good_run_q <= 1'b1;
        good_done_q <= 1'b0;
        case (gdly_q)
          2'h0: good_ms_q <= 9'd`GDLY0_MS;
          2'h1: good_ms_q <= 9'd`GDLY1_MS;
          2'h2: good_ms_q <= 9'd`GDLY2_MS;
          default: good_ms_q <= 9'd`GDLY3_MS;
        endcase
      end else if (state_q != `ST_ACTIVE) begin
        good_run_q <= 1'b0;
        good_done_q <= 1'b0;
      end else if (good_run_q && tick_q) begin
        if (good_ms_q <= 9'h001) begin
          good_run_q <= 1'b0;
          good_done_q <= 1'b1;
          aux_ok_q <= 1'b1;
        end else begin
          good_ms_q <= good_ms_q - 9'h001;
        end
      end
      if (state_q == `ST_OFF) begin
        aux_ok_q <= 1'b0;
      end
      // main good: only in completed active, low when every rail is off
      main_good_output_out <= (state_q == `ST_ACTIVE) & good_done_q & (|rail_enable_out) &
                              ~main_bad;
      // aux good survives sleep; one faulted enabled regulator pulls it low
      aux_good_output_out <= aux_ok_q & (rail_enable_out[5] | rail_enable_out[6]) &
                             ~bad[5] & ~bad[6] & (|rail_enable_out);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer in the second access cycle
  wire mapped = (paddr_in <= `ADDR_STATUS) && (paddr_in[1:0] == 2'h0);

  // enable writes during sequencing, status writes and unmapped addresses report an error
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out &
                     (~mapped | (pwrite_in & busy & (paddr_in == `ADDR_ENABLE)) |
                      (pwrite_in & (paddr_in == `ADDR_STATUS)));
      prdata_out <= 32'h00000000;
      if (psel_in & penable_in & ~pready_out & ~pwrite_in) begin
        case (paddr_in)
          `ADDR_ENABLE: prdata_out <= {25'h0000000, rail_enable_out};
          `ADDR_ORDER1: prdata_out <= {24'h000000, order_q[7:0]};
          `ADDR_ORDER2: prdata_out <= {24'h000000, order_q[15:8]};
          `ADDR_ORDER3: prdata_out <= {24'h000000, order_q[23:16]};
          `ADDR_ORDER4: prdata_out <= {28'h0000000, order_q[27:24]};
          `ADDR_ORDER5: prdata_out <= {16'h0000, gaps_q[15:0]};
          `ADDR_ORDER6: prdata_out <= {20'h00000, off_bit_q, instant_q, down_bit_q, up_bit_q,
                                       gaps_q[23:16]};
          `ADDR_GOODCFG: prdata_out <= {26'h0000000, regcfg_q, mask_q, gdly_q};
          `ADDR_STATUS: prdata_out <= {19'h00000, aux_good_output_out, main_good_output_out,
                                       aon_rails & rail_enable_out, busy, state_q};
          default: prdata_out <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ---- tb/rail_seq_props.sv ----
// concurrent checks on the rail sequencer top-level ports
// assumes a bind from the bench top; one clock, synchronous active-high reset
`timescale 1ns/1ps
module rail_seq_props (
  input wire clock_in,
  input wire sys_rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire undervoltage_lockout_in,
  input wire [6:0] rail_enable_out,
  input wire main_good_output_out,
  input wire aux_good_output_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  ////////////////////////////////////////////////////////////////////////////
  // apb phases
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_access;
    psel_in && penable_in;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // reset is checked with no disable, it is the cause itself
  AST_RST_QUIET: assert property (disable iff (1'b0) $fell(sys_rst_in) |->
    rail_enable_out == 7'h00 && !main_good_output_out && !aux_good_output_out)
    else $error("outputs not cleared by reset");
  AST_APB_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready_out ##1 pready_out)
    else $error("apb answer not after exactly one wait state");
  AST_READY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("pready held longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data not zero outside answer");
  AST_FAULT_OFF: assert property (undervoltage_lockout_in |=> rail_enable_out == 7'h00)
    else $error("rails not cut after lockout");
  AST_MAIN_NO_RAIL: assert property (rail_enable_out == 7'h00 |=> !main_good_output_out)
    else $error("main good high with all rails off");
  AST_AUX_NO_AON: assert property (rail_enable_out[6:5] == 2'b00 |=> !aux_good_output_out)
    else $error("aux good high with both always-on rails off");
endmodule

// ---- tb/rail_load_model.sv ----
// behavioural rail loads: each rail reports good a fixed lag after enable
// assumes enables from the sequencer and a fault mask from the bench
`timescale 1ns/1ps
module rail_load_model #(
  parameter LAG = 8
) (
  input wire clock_in,
  input wire [6:0] rail_enable_in,
  input wire [6:0] fault_in,
  output logic [6:0] rail_good_out
);
  logic [6:0] pipe_q [0:31];

  ////////////////////////////////////////////////////////////////////////////
  // soft start; a disabled rail is discharged so its good line reads low
  always @(posedge clock_in) begin
    pipe_q[0] <= rail_enable_in;
    for (int i = 1; i < 32; i++) begin
      pipe_q[i] <= pipe_q[i-1] & rail_enable_in;
    end
  end
  assign rail_good_out = pipe_q[LAG-1] & rail_enable_in & ~fault_in; // long lag probes late monitoring
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the rail sequencer, apb master and rail loads
// assumes short tick and timeout parameters so a run stays a few thousand cycles
`timescale 1ns/1ps
`include "rail_seq_map.vh"
module tb_top;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic power_hold_input_in = 1'b1;
  logic button_input_n_in = 1'b1;
  logic usb_in = 1'b0;
  logic adaptor_in = 1'b0;
  logic undervoltage_lockout_in = 1'b0;
  logic overtemp_shutdown_in = 1'b0;
  logic hard_reset_input_n_in = 1'b1;
  logic [6:0] rail_fault = 7'h00;
  wire [31:0] prdata_out;
  wire pready_out;
  wire pslverr_out;
  wire [6:0] rail_good_in;
  wire [6:0] rail_enable_out;
  wire main_good_output_out;
  wire aux_good_output_out;
  int failures = 0;
  int cmp_count = 0;
  int wn;
  logic [31:0] rd;
  logic er;

  // 100 MHz clock
  always #5 clock_in = ~clock_in;

  // 1 ms is ten cycles here
  rail_sequencer_power_good #(.TICK_CYCLES(10), .HOLD_TIMEOUT_MS(20), .LONG_PRESS_MS(20))
    rail_sequencer_power_good_i (.clock_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .power_hold_input_in,
    .button_input_n_in, .hard_reset_input_n_in, .usb_in, .adaptor_in,
    .undervoltage_lockout_in, .overtemp_shutdown_in, .rail_good_in, .rail_enable_out,
    .main_good_output_out, .aux_good_output_out);
  // slow loads: good only 3 ms after enable
  rail_load_model #(.LAG(30)) rail_load_model_i (.clock_in, .rail_enable_in(rail_enable_out),
    .fault_in(rail_fault), .rail_good_out(rail_good_in));

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus and wait helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chkb(er, ee);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chkb(er, ee);
  endtask
  task automatic wait_en(input logic [6:0] m, input logic [6:0] v, input int lim);
    wn = 0;
    while ((rail_enable_out & m) !== v && wn < lim) begin
      @(posedge clock_in);
      wn++;
    end
    chk({25'h0, rail_enable_out & m}, {25'h0, v});
  endtask
  task automatic wait_main(input int lim);
    wn = 0;
    while (main_good_output_out !== 1'b1 && wn < lim) begin
      @(posedge clock_in);
      wn++;
    end
    chkb(main_good_output_out, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    chk({25'h0, rail_enable_out}, 32'h0);
    rchk(`ADDR_ORDER1, 32'h21, 1'b0);
    rchk(`ADDR_ORDER4, 32'he, 1'b0);
    rchk(`ADDR_ORDER5, 32'h1111, 1'b0);
    rchk(`ADDR_ORDER6, 32'h811, 1'b0);
    rchk(`ADDR_GOODCFG, 32'h3c, 1'b0);
    rchk(8'h24, 32'h0, 1'b1);
    wr(`ADDR_STATUS, 32'h0, 1'b1);
  endtask
  task automatic t_button_up;
    button_input_n_in <= 1'b0; // hold already high
    wait_en(7'h7f, 7'h20, 5);
    button_input_n_in <= 1'b1;
    wait_en(7'h7f, 7'h21, 5);
    wait_en(7'h02, 7'h02, 40);
    chk({29'h0, rail_enable_out[4:2]}, 32'h0);
    wait_en(7'h7f, 7'h7f, 200);
    chkb(main_good_output_out, 1'b0);
    wait_main(600);
    chkb(wn > 200 && wn < 300, 1'b1);
    chkb(aux_good_output_out, 1'b1);
  endtask
  task automatic t_instant_down;
    wr(`ADDR_ORDER5, 32'h0, 1'b0);
    wr(`ADDR_ORDER6, 32'he11, 1'b0);
    wait_en(7'h10, 7'h00, 20);
    chk({28'h0, rail_enable_out[3:0]}, 32'h0);
    wait_en(7'h7f, 7'h00, 100);
    repeat (2) @(posedge clock_in);
    chkb(main_good_output_out, 1'b0);
    chkb(aux_good_output_out, 1'b0);
    rchk(`ADDR_ORDER5, 32'h1111, 1'b0);
  endtask
  task automatic t_sleep_and_up_bit;
    usb_in <= 1'b1;
    wait_en(7'h7f, 7'h7f, 300);
    wait_main(400);
    wr(`ADDR_ORDER6, 32'h011, 1'b0);
    power_hold_input_in <= 1'b0;
    wait_en(7'h10, 7'h00, 60);
    chk({28'h0, rail_enable_out[3:0]}, 32'hf);
    wait_en(7'h1f, 7'h00, 200);
    chk({30'h0, rail_enable_out[6:5]}, 32'h3);
    chkb(main_good_output_out, 1'b0);
    chkb(aux_good_output_out, 1'b1);
    power_hold_input_in <= 1'b1;
    wait_en(7'h7f, 7'h7f, 300);
    wait_main(400);
    wr(`ADDR_ORDER6, 32'h911, 1'b0);
    wr(`ADDR_ENABLE, 32'h7f, 1'b1);
    wn = 0;
    do begin
      apb(1'b0, `ADDR_ORDER6, 32'h0);
      wn++;
    end while (rd[8] !== 1'b0 && wn < 80);
    chk(rd, 32'h811);
    chkb(er, 1'b0);
    wait_main(300);
    wr(`ADDR_ENABLE, 32'h7e, 1'b0);
    rchk(`ADDR_ENABLE, 32'h7e, 1'b0);
    chkb(main_good_output_out, 1'b1);
  endtask
  task automatic t_fault;
    hard_reset_input_n_in <= 1'b0;
    wait_en(7'h7f, 7'h00, 200);
    hard_reset_input_n_in <= 1'b1;
    wait_en(7'h7f, 7'h7f, 300);
    rail_fault <= 7'h02;
    wait_en(7'h7f, 7'h00, 10);
    rail_fault <= 7'h00;
    // an over-temperature device must not wake on a supply edge
    overtemp_shutdown_in <= 1'b1;
    usb_in <= 1'b0;
    @(posedge clock_in);
    usb_in <= 1'b1;
    repeat (5) @(posedge clock_in);
    chk({25'h0, rail_enable_out}, 32'h0);
    overtemp_shutdown_in <= 1'b0;
    usb_in <= 1'b0;
    @(posedge clock_in);
    usb_in <= 1'b1;
    wait_en(7'h7f, 7'h7f, 300);
    undervoltage_lockout_in <= 1'b1;
    wait_en(7'h7f, 7'h00, 5);
    undervoltage_lockout_in <= 1'b0;
    chkb(main_good_output_out, 1'b0);
  endtask
  task automatic t_timeout;
    power_hold_input_in <= 1'b0;
    @(posedge clock_in);
    adaptor_in <= 1'b1;
    wait_en(7'h20, 7'h20, 5);
    wait_en(7'h7f, 7'h00, 400);
    chkb(wn > 290 && wn < 350, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict and run control
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_regs();
    @(posedge clock_in);
    t_button_up();
    t_instant_down();
    t_sleep_and_up_bit();
    t_fault();
    t_timeout();
    final_report();
  end
  // watchdog, well above the few thousand cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clock_in);
    failures++;
    final_report();
  end
endmodule

bind rail_sequencer_power_good rail_seq_props rail_seq_props_i (.clock_in, .sys_rst_in, .psel_in,
  .penable_in, .prdata_out, .pready_out, .pslverr_out, .undervoltage_lockout_in, .rail_enable_out,
  .main_good_output_out, .aux_good_output_out);
